// ===== design/adcp_pkg.sv
// Purpose: Shared constants and types for the converter power control
// Assumes: 40 MHz core clock
// Notes:   Control byte layout lives in adcp_ctrl_t
package adcp_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_FREQ_MHZ   = 40;
  localparam int CONV_TIME_NS   = 7700;
  // Least time, rounded up to whole cycles
  localparam int CONV_CYCLES    = (CONV_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int CONV_CNT_W     = 9;

  //////////////////////////////////////////////////////////////////////////
  // Result coding
  localparam int RES_W          = 12;
  localparam int FULL_SCALE_CODES = 4096;
  localparam int RES_HI_LSB     = 4;

  //////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int ADDR_W         = 2;
  localparam int DATA_W         = 8;
  localparam logic [1:0] ADDR_CTRL   = 2'h0;
  localparam logic [1:0] ADDR_RES_HI = 2'h1;
  localparam logic [1:0] ADDR_RES_LO = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [11:0] RES_RST    = 12'h000;
  localparam logic [7:0] RDATA_IDLE  = 8'h00;
  localparam logic [3:0] RES_LO_PAD  = 4'h0;

  //////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic       start_bit;
    logic [2:0] chan_sel;
    logic       range_sel;
    logic       polarity_select;
    logic       power_mode_bit1;
    logic       power_mode_bit0;
  } adcp_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ACQ    = 3'h1,
    ST_CONV   = 3'h3,
    ST_LOWPWR = 3'h2,
    ST_HWSD   = 3'h6
  } adcp_state_t;

  typedef enum logic [1:0] {
    PM_NORMAL  = 2'h0,
    PM_STANDBY = 2'h1,
    PM_FULL    = 2'h2
  } adcp_pmode_t;

  typedef struct packed {
    logic analog_en;
    logic bandgap_en;
    logic refbuf_en;
    logic standby_powerdown;
    logic full_powerdown;
  } adcp_power_t;

  typedef struct packed {
    logic addr_wr_match;
    logic bit_rx;
    logic stop_seen;
  } adcp_bus_evt_t;

  typedef struct packed {
    logic        result_valid;
    logic        wake_armed;
    adcp_pmode_t pmode;
    logic        hw_shutdown;
    adcp_state_t state;
  } adcp_status_t;

endpackage : adcp_pkg

// ===== design/adcp_power_ctrl.sv
// Purpose: Power-state, conversion sequencing and output coding control
// Assumes: Two-wire framing decoded elsewhere into strobes and pulses
// Notes:   Register reads work in every power state
//          A control write while shut down is dropped
//          An aborted conversion keeps the previous result
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps

module adcp_power_ctrl #(
  parameter int CONV_CYCLES = adcp_pkg::CONV_CYCLES
) (
  input  wire logic                   core_clk_i,       // Core clock
  input  wire logic                   rstn_i,           // Sync reset, low
  input  wire logic [1:0]             bus_addr_i,       // Register index
  input  wire logic [7:0]             bus_wdata_i,      // Write data
  input  wire logic                   bus_wr_i,         // Write strobe
  input  wire logic                   bus_rd_i,         // Read strobe
  output logic      [7:0]             bus_rdata_o,      // Read data
  input  wire adcp_pkg::adcp_bus_evt_t bus_evt_i,       // Framing pulses
  input  wire logic                   shutdown_pin_n_i, // Shutdown pin
  input  wire logic [11:0]            sar_code_i,       // Raw offset code
  output logic      [2:0]             chan_sel_o,       // Channel select
  output logic                        range_sel_o,      // Range select
  output logic                        acquire_o,        // Track phase
  output logic                        convert_o,        // Convert phase
  output adcp_pkg::adcp_power_t       power_o           // Analog enables
);

  //////////////////////////////////////////////////////////////////////////
  // State
  adcp_pkg::adcp_state_t  state_r;
  adcp_pkg::adcp_state_t  state_nxt;
  adcp_pkg::adcp_pmode_t  pmode_r;
  adcp_pkg::adcp_pmode_t  pmode_nxt;
  adcp_pkg::adcp_ctrl_t   ctrl_r;
  adcp_pkg::adcp_power_t  power_r;
  adcp_pkg::adcp_power_t  power_nxt;
  logic [11:0]            result_r;
  logic                   result_valid_r;
  logic                   wake_armed_r;
  logic [8:0]             conv_cnt_r;
  logic [7:0]             rdata_r;
  logic                   acquire_r;
  logic                   convert_r;
  logic [2:0]             chan_sel_r;
  logic                   range_sel_r;

  // Shutdown pin synchroniser
  logic                   sd_meta_r;
  logic                   sd_s2_r;
  logic                   sd_s3_r;
  logic                   sd_level_r;
  wire logic              sd_agree = (sd_s2_r == sd_s3_r);

  //////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic        hw_sd     = !sd_level_r;
  wire logic        in_acq    = (state_r == adcp_pkg::ST_ACQ);
  wire logic        in_conv   = (state_r == adcp_pkg::ST_CONV);
  wire logic        in_lowpwr = (state_r == adcp_pkg::ST_LOWPWR);

  // Control byte writes; refused while converting or shut down
  wire logic        ctrl_wr   = bus_wr_i &&
                                (bus_addr_i == adcp_pkg::ADDR_CTRL);
  wire logic        ctrl_take = ctrl_wr && !hw_sd && !in_conv;
  wire logic        stop_go   = in_acq && bus_evt_i.stop_seen && !ctrl_take;

  // Conversion timer end point
  wire logic [8:0]  conv_last = 9'(CONV_CYCLES - 1);
  wire logic        conv_done = in_conv && (conv_cnt_r == conv_last);
  wire logic [8:0]  conv_inc  = conv_cnt_r + 9'h001;

  // Wake from software power-down: address match, then one more bit
  wire logic        wake      = in_lowpwr && wake_armed_r &&
                                bus_evt_i.bit_rx;
  wire logic        arm_set   = in_lowpwr && bus_evt_i.addr_wr_match;
  wire logic        arm_clr   = !in_lowpwr || wake;
  wire adcp_pkg::adcp_ctrl_t wr_ctrl = adcp_pkg::adcp_ctrl_t'(bus_wdata_i);

  // Power mode requested by the latched control byte
  wire logic        pd_req    = ctrl_r.power_mode_bit1;
  wire adcp_pkg::adcp_pmode_t req_mode =
    !pd_req ? adcp_pkg::PM_NORMAL :
    (ctrl_r.power_mode_bit0 ? adcp_pkg::PM_FULL
                            : adcp_pkg::PM_STANDBY);

  // Output coding of the raw offset-binary code
  wire logic [11:0] coded = ctrl_r.polarity_select ?
                            {~sar_code_i[11], sar_code_i[10:0]} :
                            sar_code_i;

  // Read selection
  wire adcp_pkg::adcp_status_t status = '{
    result_valid: result_valid_r,
    wake_armed:   wake_armed_r,
    pmode:        pmode_r,
    hw_shutdown:  hw_sd,
    state:        state_r
  };
  wire logic [7:0]  res_hi    = result_r[11:adcp_pkg::RES_HI_LSB];
  wire logic [7:0]  res_lo    = {result_r[3:0], adcp_pkg::RES_LO_PAD};
  wire logic        sel_ctrl  = (bus_addr_i == adcp_pkg::ADDR_CTRL);
  wire logic        sel_hi    = (bus_addr_i == adcp_pkg::ADDR_RES_HI);
  wire logic        sel_lo    = (bus_addr_i == adcp_pkg::ADDR_RES_LO);
  wire logic [7:0]  rd_mux    =
    sel_ctrl ? ctrl_r :
    sel_hi   ? res_hi :
    sel_lo   ? res_lo :
               status;

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_nxt = state_r;
    pmode_nxt = pmode_r;
    if (hw_sd) begin
      state_nxt = adcp_pkg::ST_HWSD;
      pmode_nxt = adcp_pkg::PM_FULL;
    end else begin
      case (state_r)
        adcp_pkg::ST_IDLE: begin
          if (ctrl_take) begin
            state_nxt = adcp_pkg::ST_ACQ;
          end
        end
        adcp_pkg::ST_ACQ: begin
          if (stop_go) begin
            state_nxt = adcp_pkg::ST_CONV;
          end
        end
        adcp_pkg::ST_CONV: begin
          if (conv_done) begin
            if (pd_req) begin
              state_nxt = adcp_pkg::ST_LOWPWR;
              pmode_nxt = req_mode;
            end else begin
              state_nxt = adcp_pkg::ST_IDLE;
            end
          end
        end
        adcp_pkg::ST_LOWPWR: begin
          if (ctrl_take) begin
            state_nxt = adcp_pkg::ST_ACQ;
            pmode_nxt = adcp_pkg::PM_NORMAL;
          end else if (wake) begin
            state_nxt = adcp_pkg::ST_IDLE;
            pmode_nxt = adcp_pkg::PM_NORMAL;
          end
        end
        adcp_pkg::ST_HWSD: begin
          if (ctrl_take) begin
            state_nxt = adcp_pkg::ST_ACQ;
          end else begin
            state_nxt = adcp_pkg::ST_IDLE;
          end
          pmode_nxt = adcp_pkg::PM_NORMAL;
        end
        default: begin
          state_nxt = adcp_pkg::ST_IDLE;
          pmode_nxt = adcp_pkg::PM_NORMAL;
        end
      endcase
    end
  end

  // Analog enables follow the next power mode
  always_comb begin
    power_nxt                   = '0;
    power_nxt.bandgap_en        = 1'b1;
    power_nxt.analog_en         = (pmode_nxt == adcp_pkg::PM_NORMAL);
    power_nxt.refbuf_en         = (pmode_nxt != adcp_pkg::PM_FULL);
    power_nxt.standby_powerdown = (pmode_nxt == adcp_pkg::PM_STANDBY);
    power_nxt.full_powerdown    = (pmode_nxt == adcp_pkg::PM_FULL);
  end

  //////////////////////////////////////////////////////////////////////////
  // Shutdown pin: change counts once second and third stages agree
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sd_meta_r <= 1'b1;
      sd_s2_r   <= 1'b1;
      sd_s3_r   <= 1'b1;
    end else begin
      sd_meta_r <= shutdown_pin_n_i;
      sd_s2_r   <= sd_meta_r;
      sd_s3_r   <= sd_s2_r;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sd_level_r <= 1'b1;
    end else if (sd_agree) begin
      sd_level_r <= sd_s3_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer and power outputs
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_r <= adcp_pkg::ST_IDLE;
      pmode_r <= adcp_pkg::PM_NORMAL;
      power_r <= '{analog_en:         1'b1,
                   bandgap_en:        1'b1,
                   refbuf_en:         1'b1,
                   standby_powerdown: 1'b0,
                   full_powerdown:    1'b0};
    end else begin
      state_r <= state_nxt;
      pmode_r <= pmode_nxt;
      power_r <= power_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Phase outputs follow the next state
  wire logic        acq_nxt   = (state_nxt == adcp_pkg::ST_ACQ);
  wire logic        conv_nxt  = (state_nxt == adcp_pkg::ST_CONV);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      acquire_r <= 1'b0;
      convert_r <= 1'b0;
    end else begin
      acquire_r <= acq_nxt;
      convert_r <= conv_nxt;
    end
  end

  // Conversion timer, cleared on every entry
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      conv_cnt_r <= '0;
    end else if (!in_conv) begin
      conv_cnt_r <= '0;
    end else if (!conv_done) begin
      conv_cnt_r <= conv_inc;
    end
  end

  // Wake needs the address match first; set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wake_armed_r <= 1'b0;
    end else if (arm_set) begin
      wake_armed_r <= 1'b1;
    end else if (arm_clr) begin
      wake_armed_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control byte
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ctrl_r <= adcp_pkg::adcp_ctrl_t'(adcp_pkg::CTRL_RST);
    end else if (ctrl_take) begin
      ctrl_r <= wr_ctrl;
    end
  end

  // Mux settings held steady through conversion; a control write during acquisition reloads them
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      chan_sel_r  <= 3'h0;
      range_sel_r <= 1'b0;
    end else if (ctrl_take) begin
      chan_sel_r  <= wr_ctrl.chan_sel;
      range_sel_r <= wr_ctrl.range_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result; an aborted conversion leaves the old value
  wire logic        result_load = conv_done && !hw_sd;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      result_r       <= adcp_pkg::RES_RST;
      result_valid_r <= 1'b0;
    end else if (result_load) begin
      result_r       <= coded;
      result_valid_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register reads, answered in every state
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rdata_r <= adcp_pkg::RDATA_IDLE;
    end else if (bus_rd_i) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= adcp_pkg::RDATA_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign bus_rdata_o = rdata_r;
  assign chan_sel_o  = chan_sel_r;
  assign range_sel_o = range_sel_r;
  assign acquire_o   = acquire_r;
  assign convert_o   = convert_r;
  assign power_o     = power_r;

endmodule : adcp_power_ctrl

// ===== dv/adcp_power_ctrl_props.sv
// Purpose: Port-level checks for the converter power control
// Assumes: One clock domain, sync active-low reset
// Notes:   Bound to every adcp_power_ctrl instance
`timescale 1ns/100ps
module adcp_power_ctrl_props #(
  parameter int CONV_CYCLES = adcp_pkg::CONV_CYCLES
) (
  input wire logic                    core_clk_i,       // Clock
  input wire logic                    rstn_i,           // Reset, low
  input wire logic [1:0]              bus_addr_i,       // Index
  input wire logic [7:0]              bus_wdata_i,      // Write data
  input wire logic                    bus_wr_i,         // Write strobe
  input wire logic                    bus_rd_i,         // Read strobe
  input wire logic [7:0]              bus_rdata_o,      // Read data
  input wire adcp_pkg::adcp_bus_evt_t bus_evt_i,        // Framing pulses
  input wire logic                    shutdown_pin_n_i, // Shutdown pin
  input wire logic [11:0]             sar_code_i,       // Raw code
  input wire logic [2:0]              chan_sel_o,       // Channel
  input wire logic                    range_sel_o,      // Range
  input wire logic                    acquire_o,        // Track phase
  input wire logic                    convert_o,        // Convert phase
  input wire adcp_pkg::adcp_power_t   power_o           // Enables
);
  logic [9:0] conv_cnt_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  ////////////////////////////////////////////////////////////////////////
  // Length of the convert phase
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || !convert_o) conv_cnt_r <= 10'h000;
    else conv_cnt_r <= conv_cnt_r + 10'h001;
  end

  sequence s_wake;
    bus_evt_i.addr_wr_match ##1 bus_evt_i.bit_rx;
  endsequence
  sequence s_pin_low;
    !shutdown_pin_n_i [*7];
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_reset_normal: assert property (disable iff (1'b0)
    !rstn_i |=> power_o == 5'h1c && !acquire_o && !convert_o)
    else $error("outputs not in normal idle after reset");
  a_rdata_idle: assert property (!bus_rd_i |=> bus_rdata_o == 8'h00)
    else $error("read data not zero outside read slot");
  a_stop_convert: assert property (acquire_o && bus_evt_i.stop_seen
    && !bus_wr_i && shutdown_pin_n_i |=> convert_o && !acquire_o)
    else $error("stop did not start conversion");
  a_conv_length: assert property ($fell(convert_o) && shutdown_pin_n_i
    |-> conv_cnt_r == 10'(CONV_CYCLES))
    else $error("conversion length wrong");
  a_conv_powered: assert property (convert_o |-> power_o == 5'h1c)
    else $error("power-down during conversion");
  a_stby_refs: assert property (power_o.standby_powerdown
    |-> power_o.bandgap_en && power_o.refbuf_en && !power_o.full_powerdown)
    else $error("standby reference enables wrong");
  a_full_refs: assert property (power_o.full_powerdown
    |-> power_o.bandgap_en && !power_o.refbuf_en && !power_o.analog_en)
    else $error("full power-down enables wrong");
  a_shutdown_pin_n_fast: assert property (s_pin_low
    |-> power_o.full_powerdown && !acquire_o && !convert_o)
    else $error("shutdown pin not obeyed");
  a_wake_up: assert property ((power_o.standby_powerdown
    && shutdown_pin_n_i) ##0 s_wake |=> power_o == 5'h1c)
    else $error("no wake after address and bit");
endmodule : adcp_power_ctrl_props

bind adcp_power_ctrl adcp_power_ctrl_props #(.CONV_CYCLES(CONV_CYCLES))
  u_props (.core_clk_i, .rstn_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i,
  .bus_rd_i, .bus_rdata_o, .bus_evt_i, .shutdown_pin_n_i, .sar_code_i,
  .chan_sel_o, .range_sel_o, .acquire_o, .convert_o, .power_o);

// ===== dv/adcp_host_model.sv
// Purpose: Two-wire host stand-in giving framer event pulses
// Assumes: Pulses change just after a rising edge
// Notes:   Wake can be prompt or leave idle gaps
`timescale 1ns/100ps
module adcp_host_model (
  input  wire logic              clk_i, // Clock
  output adcp_pkg::adcp_bus_evt_t evt_o  // Framer pulses
);
  localparam adcp_pkg::adcp_bus_evt_t E_ADDR = 3'h4;
  localparam adcp_pkg::adcp_bus_evt_t E_BIT  = 3'h2;
  localparam adcp_pkg::adcp_bus_evt_t E_STOP = 3'h1;

  initial evt_o = 3'h0;

  task automatic pulse(input adcp_pkg::adcp_bus_evt_t e);
    @(posedge clk_i);
    evt_o <= e;
    @(posedge clk_i);
    evt_o <= 3'h0;
  endtask : pulse

  task automatic stop_pulse;
    pulse(E_STOP);
  endtask : stop_pulse

  task automatic bit_only;
    pulse(E_BIT);
  endtask : bit_only

  // Write address match, then the following bit
  task automatic wake(input logic fast);
    if (fast) begin
      @(posedge clk_i);
      evt_o <= E_ADDR;
      @(posedge clk_i);
      evt_o <= E_BIT;
      @(posedge clk_i);
      evt_o <= 3'h0;
    end else begin
      pulse(E_ADDR);
      repeat (2) @(posedge clk_i);
      pulse(E_BIT);
    end
  endtask : wake
endmodule : adcp_host_model

// ===== dv/tb_adc_power_mode_control.sv
// Purpose: Self-checking bench for the converter power control
// Assumes: Host model gives framing pulses, bench owns register port
// Notes:   Conversion shortened to 40 cycles
`timescale 1ns/100ps
module tb_adc_power_mode_control;
  localparam int CONV = 40;
  localparam adcp_pkg::adcp_power_t P_NORM = 5'h1c;
  localparam adcp_pkg::adcp_power_t P_STBY = 5'h0e;
  localparam adcp_pkg::adcp_power_t P_FULL = 5'h09;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic [1:0]              addr = 2'h0;
  logic [7:0]              wdata = 8'h00;
  logic                    wr_s = 1'b0;
  logic                    rd_s = 1'b0;
  logic                    sd_n = 1'b1;
  logic [11:0]             sar = 12'h000;
  logic [7:0]              rdata;
  adcp_pkg::adcp_bus_evt_t evt;
  logic [2:0]              chan;
  logic                    rng;
  logic                    acq;
  logic                    cnv;
  adcp_pkg::adcp_power_t   pwr;
  int                      failures = 0;
  int                      tests_run = 0;
  logic [11:0]             corner [3] = '{12'h000, 12'hfff, 12'h800};

  always #12.5 clk = ~clk;

  adcp_power_ctrl #(.CONV_CYCLES(CONV)) dut (
    .core_clk_i(clk), .rstn_i(rst_n), .bus_addr_i(addr),
    .bus_wdata_i(wdata), .bus_wr_i(wr_s), .bus_rd_i(rd_s),
    .bus_rdata_o(rdata), .bus_evt_i(evt), .shutdown_pin_n_i(sd_n),
    .sar_code_i(sar), .chan_sel_o(chan), .range_sel_o(rng),
    .acquire_o(acq), .convert_o(cnv), .power_o(pwr));

  adcp_host_model hm (.clk_i(clk), .evt_o(evt));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [11:0] code(input logic [11:0] s, input logic b);
    code = b ? {~s[11], s[10:0]} : s;
  endfunction : code

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chkp(input adcp_pkg::adcp_power_t got,
                      input adcp_pkg::adcp_power_t exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkp

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk8(rdata, e);
  endtask : rd

  task automatic start(input logic [7:0] c);
    wr(2'h0, c);
    #1;
    chk8({chan, rng, acq, cnv, 2'h0}, {c[6:3], 4'h8});
    hm.stop_pulse();
    #1;
    chk8({chan, rng, acq, cnv, 2'h0}, {c[6:3], 4'h4});
    chkp(pwr, P_NORM);
  endtask : start

  task automatic conv(input logic [7:0] c);
    logic [11:0] e;
    start(c);
    for (int n = 0; n < CONV + 5 && cnv; n++) @(posedge clk);
    #1;
    e = code(sar, c[2]);
    rd(2'h1, e[11:4]);
    rd(2'h2, {e[3:0], 4'h0});
  endtask : conv

  task automatic print_verdict;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [7:0]  h;
    r = 32'hf10b;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chkp(pwr, P_NORM);
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
    wr(2'h1, 8'hff);
    rd(2'h1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      @(posedge clk);
      sar <= (i < 3) ? corner[i] : r[11:0];
      conv({1'b1, r[18:15], i[0], 2'h0});
    end
    for (int m = 1; m < 4; m++) begin
      conv({6'h20, m[1:0]});
      chkp(pwr, m == 1 ? P_NORM : m == 2 ? P_STBY : P_FULL);
      hm.bit_only();
      #1;
      chkp(pwr, m == 1 ? P_NORM : m == 2 ? P_STBY : P_FULL);
      hm.wake(m != 3);
      #1;
      chkp(pwr, P_NORM);
    end
    repeat (2) begin
      conv(8'h82);
      chkp(pwr, P_STBY);
    end
    hm.wake(1'b1);
    h = sar[11:4];
    sar <= 12'h5a5;
    start(8'h80);
    @(posedge clk);
    sd_n <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chkp(pwr, P_FULL);
    chk8({6'h0, acq, cnv}, 8'h00);
    rd(2'h1, h);
    rd(2'h3, 8'hae);
    wr(2'h0, 8'h8e);
    sd_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chkp(pwr, P_NORM);
    chk8({6'h0, acq, cnv}, 8'h00);
    rd(2'h3, 8'h80);
    rd(2'h0, 8'h80);
    conv(8'h84);
    print_verdict;
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    print_verdict;
  end
endmodule : tb_adc_power_mode_control
